// File: sodc_host.sv
// Host end: AHB-Lite register slave driving one eight-bit link transfer.
`timescale 1ns/100ps
module sodc_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sodc_if.host             link
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG} sodc_hstate_t;
  typedef struct packed {
    sodc_hstate_t fsm;
    logic [1:0]   sdo_s;
    logic [7:0]   tx;
    logic [7:0]   rx;
    logic [7:0]   cnt;
    logic [3:0]   bits;
    logic         done;
    logic         sel_n;
    logic         sclk;
    logic         sdi;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic [31:0]  rdata;
  } sodc_host_state_t;

  sodc_host_state_t state_reg;
  sodc_host_state_t state_next;
  logic             addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next         = state_reg;
    state_next.sdo_s   = {state_reg.sdo_s[0], link.sdo_wire};
    addr_ok            = hsel & htrans[1];
    state_next.wr_pend = addr_ok & hwrite;
    state_next.wr_addr = haddr[7:0];
    if (addr_ok & ~hwrite) begin
      case (haddr[7:0])
        sodc_pkg::ADDR_CTRL:   state_next.rdata = {24'h000000, state_reg.tx};
        sodc_pkg::ADDR_STATUS: state_next.rdata = {30'h00000000, state_reg.done,
                                                   state_reg.fsm != H_IDLE};
        sodc_pkg::ADDR_DIAG:   state_next.rdata = {24'h000000, state_reg.rx};
        default:               state_next.rdata = 32'h00000000;
      endcase
    end
    if (state_reg.cnt != 8'h00) begin
      state_next.cnt = state_reg.cnt - 8'h01;
    end
    case (state_reg.fsm)
      H_IDLE: begin
        if (state_reg.wr_pend && state_reg.wr_addr == sodc_pkg::ADDR_CTRL &&
            hwdata[sodc_pkg::CTRL_START_BIT]) begin
          state_next.tx    = hwdata[7:0];
          state_next.sel_n = 1'b0; // Shift clock stays low at this edge
          state_next.sdi   = hwdata[7];
          state_next.bits  = 4'h0;
          state_next.done  = 1'b0;
          state_next.cnt   = 8'(sodc_pkg::LEAD_CYCLES);
          state_next.fsm   = H_LEAD;
        end else if (state_reg.wr_pend && state_reg.wr_addr == sodc_pkg::ADDR_STATUS &&
                     hwdata[sodc_pkg::STAT_DONE_BIT]) begin
          state_next.done = 1'b0;
        end
      end
      H_LEAD: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.sclk = 1'b1;
          state_next.cnt  = 8'(sodc_pkg::HALF_CYCLES);
          state_next.fsm  = H_HIGH;
        end
      end
      H_LOW: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.sclk = 1'b1;
          state_next.cnt  = 8'(sodc_pkg::HALF_CYCLES);
          state_next.fsm  = H_HIGH;
        end else if (state_reg.cnt == 8'(sodc_pkg::HALF_CYCLES / 2)) begin
          // The next bit moves mid-low, so the fall that captured the last one sees it held.
          state_next.sdi = state_reg.tx[7];
        end
      end
      H_HIGH: begin
        if (state_reg.cnt == 8'h00) begin
          // Diagnostic bit has had a whole half period to settle after the rise.
          state_next.rx   = {state_reg.rx[6:0], state_reg.sdo_s[1]};
          state_next.tx   = {state_reg.tx[6:0], state_reg.tx[7]};
          state_next.sclk = 1'b0;
          state_next.bits = state_reg.bits + 4'h1;
          state_next.cnt  = 8'(sodc_pkg::HALF_CYCLES);
          if (state_reg.bits == 4'h7) begin
            state_next.cnt = 8'(sodc_pkg::LEAD_CYCLES);
            state_next.fsm = H_LAG;
          end else begin
            state_next.fsm = H_LOW;
          end
        end
      end
      H_LAG: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.sel_n = 1'b1;
          state_next.done  = 1'b1;
          state_next.fsm   = H_IDLE;
        end
      end
      default: state_next.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= '0;
      state_reg.fsm   <= H_IDLE;
      state_reg.sel_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata     = state_reg.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign link.sel_n = state_reg.sel_n;
  assign link.sclk  = state_reg.sclk;
  assign link.sdi   = state_reg.sdi;
endmodule : sodc_host

// File: sodc_pkg.sv
// Shared constants for the serial octal driver control link.
package sodc_pkg;
  localparam int          NUM_CH          = 8;
  localparam int          CLK_PERIOD_NS   = 4;
  // Fault blanking delay, nominal and bounds, in microseconds.
  localparam int          BLANK_US        = 160;
  localparam int          BLANK_MIN_US    = 75;
  localparam int          BLANK_MAX_US    = 250;
  localparam int          BLANK_CYCLES    = BLANK_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0]  LATCH_RST       = 8'hFF;
  localparam logic [7:0]  SHIFT_RST       = 8'h00;
  // Host side: shift clock divider, half period in hclk cycles (125 ns period).
  localparam int          HALF_PERIOD_NS  = 63;
  localparam int          HALF_CYCLES     = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Chip select lead and lag time in nanoseconds.
  localparam int          LEAD_NS         = 250;
  localparam int          LEAD_CYCLES     = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host registers, byte addresses.
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_DIAG       = 8'h08;
  localparam int          CTRL_START_BIT  = 8;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_DONE_BIT   = 1;
endpackage : sodc_pkg

// File: sodc_if.sv
// Serial link between the host controller and the octal driver device.
`timescale 1ns/100ps
interface sodc_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_wire;
  // Wire level of the serial output seen by the host; pulled low when undriven.
  assign sdo_wire = sdo_oe ? sdo : 1'b0;
  modport dev  (input sel_n, input sclk, input sdi, output sdo, output sdo_oe);
  modport host (output sel_n, output sclk, output sdi, input sdo_wire);
endinterface : sodc_if

// File: sodc_device.sv
// Octal driver device end: shift register, parallel latch and fault blanking.
//
// Operation
// - Eight-bit shift register, control in, diagnostics out.
// - Serial output driven only while selected.
// - Select fall loads pin comparator levels.
// - Output shifts on rise, input captured on fall.
// - Most significant bit first, channel 7 leads.
// - Control zero means on, one means off.
// - Diagnostic one means pin above threshold.
// - Unlimited bit count passes through for chaining.
// - Select rise copies shift register into latch.
// - Select rise starts fault blanking timer.
// - After blanking, faulted on channel clears itself.
// - Shift clock ignored while select is high.
// - Host keeps shift clock low at select edges.
// - Reset sets whole latch, all outputs off.
// - Open pin programmed off reports zero.
// - Host writes, waits, rewrites, compares diagnostics.
// - Host reads one-on as short, zero-off as open.
// - Blanking delay lies within 75 to 250 us.
`timescale 1ns/100ps
module sodc_device (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  sodc_if.dev              link,
  input  wire logic [7:0]  pin_high,
  output logic      [7:0]  ch_on
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]  sel_s;
    logic [1:0]  sclk_s;
    logic [1:0]  sdi_s;
    logic [7:0]  pin_s0;
    logic [7:0]  pin_s1;
    logic        sel_d;
    logic        sclk_d;
    logic [7:0]  shift;
    logic [7:0]  latch;
    logic [17:0] blank;
    logic        sdo;
    logic        sdo_oe;
    logic [7:0]  ch_on;
  } sodc_dev_state_t;

  localparam logic [17:0] BLANK_LOAD = 18'(sodc_pkg::BLANK_CYCLES);

  sodc_dev_state_t state_reg;
  sodc_dev_state_t state_next;
  logic            sel_n_s;
  logic            sclk_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next        = state_reg;
    state_next.sel_s  = {state_reg.sel_s[0], link.sel_n};
    state_next.sclk_s = {state_reg.sclk_s[0], link.sclk};
    state_next.sdi_s  = {state_reg.sdi_s[0], link.sdi};
    // Comparator levels come from the analog side, so they pass two flops as well.
    state_next.pin_s0 = pin_high;
    state_next.pin_s1 = state_reg.pin_s0;
    sel_n_s           = state_reg.sel_s[1];
    sclk_s            = state_reg.sclk_s[1] & ~sel_n_s;
    state_next.sel_d  = sel_n_s;
    state_next.sclk_d = sclk_s;
    if (state_reg.blank != 18'h00000) begin
      state_next.blank = state_reg.blank - 18'h00001;
    end
    if (state_reg.sel_d & ~sel_n_s) begin
      state_next.shift = state_reg.pin_s1;
      state_next.sdo   = state_reg.pin_s1[7];
    end else if (~sel_n_s) begin
      if (sclk_s & ~state_reg.sclk_d) begin
        state_next.sdo = state_reg.shift[7];
      end else if (~sclk_s & state_reg.sclk_d) begin
        state_next.shift = {state_reg.shift[6:0], state_reg.sdi_s[1]};
      end
    end
    if (~state_reg.sel_d & sel_n_s) begin
      state_next.latch = state_reg.shift;
      state_next.blank = BLANK_LOAD;
    end else if (state_reg.blank == 18'h00000) begin
      state_next.latch = state_reg.latch | (~state_reg.latch & state_reg.pin_s1);
    end
    state_next.sdo_oe = ~sel_n_s;
    state_next.ch_on  = ~state_next.latch;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= '0;
      state_reg.sel_s <= 2'h3;
      state_reg.sel_d <= 1'b1;
      state_reg.latch <= sodc_pkg::LATCH_RST;
      state_reg.shift <= sodc_pkg::SHIFT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.sdo    = state_reg.sdo;
  assign link.sdo_oe = state_reg.sdo_oe;
  assign ch_on       = state_reg.ch_on;
endmodule : sodc_device

// File: sodc_link_asserts.sv
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/100ps
module sodc_link_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] rise_cnt_reg;
  ////////////////////////////////////////
  // Counts shift clock rises inside one frame; cleared while deselected.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rise_cnt_reg <= 5'h00;
    else if (sel_n) rise_cnt_reg <= 5'h00;
    else if ($rose(sclk)) rise_cnt_reg <= rise_cnt_reg + 5'h01;
  end
  sequence s_lead;
    !sclk [*8];
  endsequence
  sequence s_sdi_held;
    $stable(sdi) ##1 $stable(sdi) [*4];
  endsequence
  property p_oe_on;  !sel_n [*5] |-> sdo_oe; endproperty
  property p_oe_off; sel_n [*5] |-> !sdo_oe; endproperty
  property p_lead;   $fell(sel_n) |-> s_lead; endproperty
  property p_lag;    $rose(sel_n) |-> !sclk; endproperty
  property p_gate;   $rose(sclk) |-> !sel_n; endproperty
  property p_sdi;    $fell(sclk) |-> s_sdi_held; endproperty
  property p_count;  $rose(sel_n) |-> rise_cnt_reg == 5'h08; endproperty
  // The device moves its output only after a rise or a select fall, so a long low stretch must be quiet.
  property p_sdo;    (!sclk && !sel_n) [*8] |-> $stable(sdo); endproperty
  a_oe_on:  assert property (p_oe_on) else $error("output not driven while selected");
  a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
  a_lead:   assert property (p_lead) else $error("clock moved at select fall");
  a_lag:    assert property (p_lag) else $error("clock high at select rise");
  a_gate:   assert property (p_gate) else $error("clock rise while deselected");
  a_sdi:    assert property (p_sdi) else $error("serial input moved at capture");
  a_count:  assert property (p_count) else $error("frame not eight clocks");
  a_sdo:    assert property (p_sdo) else $error("serial output moved without rise");
endmodule : sodc_link_asserts

// File: sodc_tb.sv
// Testbench joining the host and device ends over the serial link.
`timescale 1ns/100ps
module serial_octal_driver_control_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pin_high;
  logic [7:0]  ch_on;
  logic [31:0] rd;
  int          errors;
  int          samples_checked;
  int          cyc;
  sodc_if link ();
  sodc_host sodc_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link.host));
  sodc_device sodc_device_i (.hclk(hclk), .hresetn(hresetn), .link(link.dev),
    .pin_high(pin_high), .ch_on(ch_on));
  sodc_link_asserts sodc_link_asserts_i (.hclk(hclk), .hresetn(hresetn), .sel_n(link.sel_n),
    .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
  ////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // The whole run needs about 70000 cycles, mostly two blanking waits.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic frame(input logic [7:0] ctrl, input logic [7:0] pins);
    int n;
    n = 0;
    pin_high <= pins;
    bus(1'b1, sodc_pkg::ADDR_CTRL, {23'h000000, 1'b1, ctrl});
    do begin
      bus(1'b0, sodc_pkg::ADDR_STATUS, 32'h00000000);
      n++;
    end while (rd[sodc_pkg::STAT_DONE_BIT] !== 1'b1 && n < 2000);
    check("done", rd[sodc_pkg::STAT_DONE_BIT], 32'h00000001);
    bus(1'b1, sodc_pkg::ADDR_STATUS, 32'h00000002);
    bus(1'b0, sodc_pkg::ADDR_STATUS, 32'h00000000);
    check("status_clear", rd, 32'h00000000);
    bus(1'b0, sodc_pkg::ADDR_DIAG, 32'h00000000);
    check("diag", rd, {24'h000000, pins});
    repeat (8) @(posedge hclk);
    check("ch_on", ch_on, {24'h000000, ~ctrl});
  endtask : frame
  task automatic t_reset();
    check("ch_on_reset", ch_on, 8'h00);
    check("hresp", hresp, 32'h00000000);
    bus(1'b0, sodc_pkg::ADDR_STATUS, 32'h00000000);
    check("status_reset", rd, 32'h00000000);
    bus(1'b0, 8'h0C, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
  endtask : t_reset
  task automatic t_frames();
    frame(8'h5A, 8'h18);
    frame(8'hFF, 8'h00);
    frame(8'h00, 8'h00);
    // A reset in mid-run must turn off every channel that the last frame turned on.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("ch_on_midreset", ch_on, 8'h00);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : t_frames
  task automatic t_fault();
    int n;
    n = 0;
    // Channel 4 is programmed on while its pin stays high, which is an overload.
    frame(8'h0F, 8'h10);
    repeat (25000) @(posedge hclk);
    check("ch_on_blank", ch_on, 8'hF0);
    // Rewrite before expiry: a timer that did not restart would clear too soon.
    frame(8'h0F, 8'h10);
    while (ch_on === 8'hF0 && n < 70000) begin
      @(posedge hclk);
      n++;
    end
    check("ch_on_fault", ch_on, 8'hE0);
    check("blank_len", (n >= sodc_pkg::BLANK_MIN_US * 1000 / sodc_pkg::CLK_PERIOD_NS) &&
      (n <= sodc_pkg::BLANK_MAX_US * 1000 / sodc_pkg::CLK_PERIOD_NS), 1);
  endtask : t_fault
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    pin_high = 8'h00;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_frames();
    t_fault();
    close_out();
  end
endmodule : serial_octal_driver_control_tb
